// *** epc_pkg.sv ***
package epc_pkg;
  // CPU address map
  localparam logic [15:0] EPC_CTRL_ADDR = 16'hFE1D;
  localparam logic [15:0] EPC_SHADOW_ADDR = 16'hFE1F;
  localparam logic [15:0] EPC_ARRAY_BASE = 16'h0800;
  localparam logic [15:0] EPC_ARRAY_LAST = 16'h09FF;
  // Nonvolatile config byte position, chosen
  localparam logic [15:0] EPC_NVCFG_ADDR = 16'hFE1C;
  localparam int EPC_ARRAY_BYTES = 512;
  localparam int EPC_BLOCK_BYTES = 128;
  localparam int EPC_HALF_BYTES = 256;
  localparam int EPC_NBLOCKS = 4;
  // Control register fields
  localparam int EPC_BIT_PGM = 0;
  localparam int EPC_BIT_LAT = 1;
  localparam int EPC_BIT_ERLO = 4;
  localparam int EPC_BIT_ERHI = 5;
  localparam int EPC_BIT_OFF = 6;
  localparam int EPC_BIT_BCLK = 7;
  localparam logic [7:0] EPC_CTRL_RESET = 8'h00;
  localparam logic [7:0] EPC_CTRL_RMASK = 8'hF3;
  // Config byte fields
  localparam int EPC_BIT_RED = 7;
  localparam logic [7:0] EPC_ERASED_BYTE = 8'hFF;
  localparam logic [7:0] EPC_NVCFG_INIT = 8'h00;
  typedef enum logic [1:0]
  {
    EPC_BYTE_PGM,
    EPC_BYTE_ERA,
    EPC_BLOCK_ERA,
    EPC_BULK_ERA
  } epc_mode_e;
endpackage

// *** epc_cell_array.sv ***
`timescale 1ns/1ps
module epc_cell_array
  import epc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Read port
  input wire logic [8:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] nvcfg_o,
  // Cell operation, applied each cycle while high voltage is on
  input wire logic hv_i,
  input wire logic [EPC_ARRAY_BYTES-1:0] sel_i,
  input wire logic nv_sel_i,
  input wire logic erase_i,
  input wire logic [7:0] data_i
);
  logic [7:0] mem_r [EPC_ARRAY_BYTES];
  logic [7:0] nv_r;

  assign rd_data_o = mem_r[rd_addr_i];
  assign nvcfg_o = nv_r;

  genvar g;
  generate
    for (g = 0; g < EPC_ARRAY_BYTES; g++)
    begin : g_cell
      always_ff @(posedge sys_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          mem_r[g] <= EPC_ERASED_BYTE;
        else if (hv_i && sel_i[g])
          // Erase drives to one, program only clears bits
          mem_r[g] <= erase_i ? EPC_ERASED_BYTE : (mem_r[g] & data_i);
      end
    end
  endgenerate

  // Config cell starts unprotected, not redundant
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      nv_r <= EPC_NVCFG_INIT;
    else if (hv_i && nv_sel_i)
      nv_r <= erase_i ? EPC_ERASED_BYTE : (nv_r & data_i);
  end
endmodule

// *** epc_pump.sv ***
`timescale 1ns/1ps
module epc_pump
  import epc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic pgm_i,
  input wire logic stop_i,
  input wire logic bus_clk_sel_i,
  // Pump outputs
  output logic pump_on_o,
  output logic pump_bus_clk_o,
  output logic hv_o
);
  // High voltage follows the enable; stop suspends without clearing it
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pump_on_o <= 1'b0;
      hv_o <= 1'b0;
      pump_bus_clk_o <= 1'b0;
    end
    else
    begin
      pump_on_o <= pgm_i && !stop_i;
      hv_o <= pgm_i && !stop_i;
      pump_bus_clk_o <= bus_clk_sel_i;
    end
  end
endmodule

// *** epc_top.sv ***
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module epc_top
  import epc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // CPU bus
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic sel_o,
  // Low power
  input wire logic stop_i,
  // Pump and array status
  output logic pump_on_o,
  output logic pump_bus_clk_o,
  output logic hv_o,
  output logic array_off_o
);
  import epc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Registers
  // Control and config state
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [4:0] shadow_r;

  // Captured write
  logic [8:0] lat_addr_r;
  logic [7:0] lat_data_r;
  logic lat_valid_r;
  logic nv_lat_r;
  logic nonarray_wr_r;

  // Read path and shadow load
  logic shadow_load_r;
  logic [7:0] rdata_r;
  logic sel_r;

  // Array and pump links
  logic [7:0] cell_rd;
  logic [7:0] nvcfg;
  logic hv;

  //////////////////////////////////////////////////////////////////////////
  // Address decode
  wire is_array = (addr_i >= EPC_ARRAY_BASE) && (addr_i <= EPC_ARRAY_LAST);
  wire [8:0] aoff = 9'(addr_i - EPC_ARRAY_BASE);
  wire red = shadow_r[4];
  wire [3:0] prot = shadow_r[3:0];

  // Upper half not recognised in redundant mode
  wire valid_arr = is_array && !(red && aoff[8]);
  wire is_nv = addr_i == EPC_NVCFG_ADDR;
  wire is_ctrl = addr_i == EPC_CTRL_ADDR;
  wire is_shadow = addr_i == EPC_SHADOW_ADDR;

  // Qualified strobes
  wire arr_wr = wr_i && valid_arr;
  wire nv_wr = wr_i && is_nv;
  wire ctrl_wr = wr_i && is_ctrl;

  // Control fields
  wire pgm = ctrl_r[EPC_BIT_PGM];
  wire lat = ctrl_r[EPC_BIT_LAT];
  wire [1:0] mode = {ctrl_r[EPC_BIT_ERHI], ctrl_r[EPC_BIT_ERLO]};
  wire bclk_en = ctrl_r[EPC_BIT_BCLK];
  wire pwr_off = ctrl_r[EPC_BIT_OFF];
  wire [1:0] lat_blk = lat_addr_r[8:7];

  wire latched = lat && (lat_valid_r || nv_lat_r);
  // Control writes need a valid capture first while latched
  wire ctrl_ok = !lat || latched;
  // Enable may only rise after a latched valid write
  wire pgm_ok = latched && !nonarray_wr_r;

  //////////////////////////////////////////////////////////////////////////
  // Control register next value
  // Enable may be held or dropped at will, but set only after a capture
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr && ctrl_ok)
    begin
      ctrl_nxt[EPC_BIT_BCLK] = wdata_i[EPC_BIT_BCLK];
      ctrl_nxt[EPC_BIT_OFF] = wdata_i[EPC_BIT_OFF];
      if (!pgm)
      begin
        ctrl_nxt[EPC_BIT_ERHI] = wdata_i[EPC_BIT_ERHI];
        ctrl_nxt[EPC_BIT_ERLO] = wdata_i[EPC_BIT_ERLO];
      end
      ctrl_nxt[EPC_BIT_PGM] = wdata_i[EPC_BIT_PGM] && (pgm || pgm_ok);
      // Latch cannot drop while enable was set
      ctrl_nxt[EPC_BIT_LAT] = pgm ? lat : wdata_i[EPC_BIT_LAT];
    end
  end

  // Control register
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ctrl_r <= EPC_CTRL_RESET;
    else
      ctrl_r <= ctrl_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // Address and data capture
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lat_addr_r <= 9'h000;
      lat_data_r <= 8'h00;
      lat_valid_r <= 1'b0;
      nv_lat_r <= 1'b0;
      nonarray_wr_r <= 1'b0;
    end
    else if (!lat)
    begin
      lat_valid_r <= 1'b0;
      nv_lat_r <= 1'b0;
      // Stray writes while unlatched set nonarray_wr_r; the capture the enable needs clears it again
      if (wr_i)
        nonarray_wr_r <= !(is_array || is_nv || is_ctrl);
    end
    // No capture under high voltage, so the target cannot move mid-pulse
    else if (!pgm && (arr_wr || nv_wr))
    begin
      // Later valid writes replace the pair
      lat_addr_r <= aoff;
      lat_data_r <= wdata_i;
      lat_valid_r <= arr_wr;
      nv_lat_r <= nv_wr;
      nonarray_wr_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Target selection
  logic [EPC_ARRAY_BYTES-1:0] sel;

  genvar g;
  generate
    for (g = 0; g < EPC_ARRAY_BYTES; g++)
    begin : g_sel
      localparam logic [8:0] IDX = 9'(g);
      // Lower-half address that owns this cell, mirrored in redundant mode
      wire [8:0] own = red ? {1'b0, IDX[7:0]} : IDX;
      wire hit = own == lat_addr_r;
      wire blk_hit = IDX[8:7] == lat_blk;
      wire unprot = !prot[IDX[8:7]] || (red && IDX[8]);
      // Mirror cells follow the lower-half protection, since the upper
      // protection bits only gate bulk erase in redundant mode
      wire mir_unprot = !(red && prot[{1'b0, IDX[7]}]);
      wire ok = unprot && mir_unprot && !prot[lat_blk];
      // Mode decode per cell
      always_comb
      begin
        case (epc_mode_e'(mode))
          EPC_BYTE_PGM: sel[g] = hit;
          EPC_BYTE_ERA: sel[g] = hit;
          EPC_BLOCK_ERA:
            sel[g] = red ? (IDX[7] == lat_blk[0]) : blk_hit;
          EPC_BULK_ERA: sel[g] = prot == 4'h0;
          default: sel[g] = 1'b0;
        endcase
        sel[g] = sel[g] && ok && lat_valid_r;
      end
    end
  endgenerate

  // Config byte only for byte ops
  wire nv_sel = nv_lat_r && !mode[1];
  // Any nonzero mode erases; program only in mode zero
  wire erase = mode != 2'b00;

  // Pump and voltage switch
  epc_pump u_pump
  (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pgm_i(pgm),
    .stop_i(stop_i),
    .bus_clk_sel_i(bclk_en),
    .pump_on_o(pump_on_o),
    .pump_bus_clk_o(pump_bus_clk_o),
    .hv_o(hv)
  );
  assign hv_o = hv;

  // Read address folds the upper half in redundant mode, but valid_arr zeroes those reads unless a capture is latched
  wire [8:0] rd_off = red ? {1'b0, aoff[7:0]} : aoff;
  epc_cell_array u_cells
  (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .rd_addr_i(rd_off),
    .rd_data_o(cell_rd),
    .nvcfg_o(nvcfg),
    .hv_i(hv),
    .sel_i(sel),
    .nv_sel_i(nv_sel),
    .erase_i(erase),
    .data_i(lat_data_r)
  );

  //////////////////////////////////////////////////////////////////////////
  // Shadow config: load one cycle after reset release, and on config read
  // Reset leaves the load pending, so the first edge copies the config cell
  wire nv_rd = rd_i && is_nv;
  wire [4:0] shadow_nxt = {nvcfg[EPC_BIT_RED], nvcfg[3:0]};
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      shadow_r <= 5'h00;
      shadow_load_r <= 1'b1;
    end
    else
    begin
      shadow_load_r <= 1'b0;
      if (shadow_load_r || nv_rd)
        shadow_r <= shadow_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data
  wire [7:0] shadow_rd = {shadow_r[4], 3'b000, shadow_r[3:0]};
  wire rd_hit = is_ctrl || is_shadow || is_nv || is_array;
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    if (is_ctrl)
      rd_mux = ctrl_r & EPC_CTRL_RMASK;
    else if (is_shadow)
      rd_mux = shadow_rd;
    else if (is_nv)
      rd_mux = nvcfg;
    else if (is_array && latched)
      rd_mux = lat_data_r;
    // Powered-down array reads zero rather than stale cells
    else if (valid_arr && !pwr_off)
      rd_mux = cell_rd;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_r <= 8'h00;
      sel_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rd_i ? rd_mux : 8'h00;
      sel_r <= rd_i && rd_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata_o = rdata_r;
  assign sel_o = sel_r;
  assign array_off_o = pwr_off;
endmodule

// *** epc_top_sva.sv ***
`timescale 1ns/1ps
module epc_top_chk
  import epc_pkg::*;
(
  // Watched ports
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic sel_o,
  input wire logic stop_i,
  input wire logic pump_on_o,
  input wire logic pump_bus_clk_o,
  input wire logic hv_o,
  input wire logic array_off_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic ctl_wr = wr_i && addr_i == EPC_CTRL_ADDR;
  AST_PUMP_HV: assert property (hv_o == pump_on_o)
    else $error("pump and voltage disagree");
  AST_STOP_OFF: assert property (stop_i |=> !hv_o)
    else $error("voltage on in stop");
  AST_HV_RISE: assert property ($rose(hv_o) |-> !$past(stop_i))
    else $error("voltage rose during stop");
  // Only a control write or stop may drop the voltage
  AST_HV_KEEP: assert property (hv_o && !stop_i && !ctl_wr &&
    !$past(ctl_wr) |=> hv_o) else $error("voltage dropped by itself");
  AST_HV_CLEAR: assert property (hv_o && ctl_wr &&
    !wdata_i[EPC_BIT_PGM] |=> ##1 !hv_o) else $error("voltage kept");
  AST_ARRAY_SEL: assert property (rd_i &&
    addr_i >= EPC_ARRAY_BASE && addr_i < 16'h0900 |=> sel_o)
    else $error("array read not selected");
  AST_SEL_CAUSE: assert property (sel_o |-> $past(rd_i))
    else $error("select without read");
  AST_OFF_WR: assert property ($changed(array_off_o) |->
    $past(ctl_wr)) else $error("power down changed alone");
endmodule
bind epc_top epc_top_chk u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .sel_o(sel_o), .stop_i(stop_i), .pump_on_o(pump_on_o),
  .pump_bus_clk_o(pump_bus_clk_o), .hv_o(hv_o), .array_off_o(array_off_o));

// *** epc_cpu_model.sv ***
`timescale 1ns/1ps
module epc_cpu_model
  import epc_pkg::*;
#(
  parameter int PGM_CYC = 8,
  parameter int FALL_CYC = 4
)
(
  // Clock
  input wire logic sys_clk_i,
  // Bus
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial
  begin
    addr_o = 16'h0000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Released address shows its inverse, not a stale value
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
  task automatic op(input epc_mode_e m, input logic [15:0] a,
    input logic [7:0] d);
    bus_wr(EPC_CTRL_ADDR, {2'b00, m, 4'h2});
    bus_wr(a, d);
    bus_wr(EPC_CTRL_ADDR, {2'b00, m, 4'h3});
    repeat (PGM_CYC) @(posedge sys_clk_i);
    bus_wr(EPC_CTRL_ADDR, 8'h00);
    repeat (FALL_CYC) @(posedge sys_clk_i);
    bus_wr(EPC_CTRL_ADDR, 8'h00);
  endtask
endmodule

// *** epc_top_test.sv ***
`timescale 1ns/1ps
module epc_top_test;
  import epc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic stop = 1'b0;
  logic [15:0] addr, a;
  logic [7:0] wdata, rdata, d, d2;
  logic wr, rd, sel, pump_on, bclk, hv, off;
  logic [31:0] rnd = 32'hA7051837;
  int err_total = 0;
  int n_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  epc_top dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sel_o(sel),
    .stop_i(stop), .pump_on_o(pump_on), .pump_bus_clk_o(bclk),
    .hv_o(hv), .array_off_o(off));
  epc_cpu_model cpu (.sys_clk_i(sys_clk), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] pgm_exp(input logic [7:0] o, n);
    return o & n;
  endfunction
  function automatic logic [7:0] shd(input logic [7:0] c);
    return {c[EPC_BIT_RED], 3'b000, c[3:0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [15:0] ad, input logic [7:0] e);
    logic [7:0] v;
    cpu.bus_rd(ad, v);
    check(v, e);
  endtask
  task automatic hv_is(input logic v);
    repeat (3) @(posedge sys_clk);
    #1;
    check({7'h00, hv}, {7'h00, v});
    check({7'h00, pump_on}, {7'h00, v});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (8000) @(posedge sys_clk);
    err_total++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(EPC_CTRL_ADDR, EPC_CTRL_RESET);
    rdc(EPC_SHADOW_ADDR, shd(EPC_NVCFG_INIT));
    rdc(EPC_ARRAY_BASE + 16'(rnd[8:0]), EPC_ERASED_BYTE);
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      a = 16'h0980 + 16'(i * 32) + 16'(rnd[4:0]);
      d = rnd[15:8];
      d2 = rnd[23:16];
      cpu.op(EPC_BYTE_PGM, a, d);
      rdc(a, d);
      cpu.op(EPC_BYTE_PGM, a, d2);
      rdc(a, pgm_exp(d, d2));
    end
    $display("test 1 done");
    cpu.bus_wr(EPC_CTRL_ADDR, 8'h02);
    cpu.bus_wr(16'h0901, 8'h5A);
    cpu.bus_wr(16'h0902, 8'hC3);
    rdc(16'h0800, 8'hC3);
    cpu.bus_wr(EPC_CTRL_ADDR, 8'h03);
    cpu.bus_wr(EPC_CTRL_ADDR, 8'h33);
    rdc(EPC_CTRL_ADDR, 8'h03);
    hv_is(1'b1);
    @(posedge sys_clk);
    stop <= 1'b1;
    hv_is(1'b0);
    rdc(EPC_CTRL_ADDR, 8'h03);
    @(posedge sys_clk);
    stop <= 1'b0;
    hv_is(1'b1);
    cpu.bus_wr(EPC_CTRL_ADDR, 8'h00);
    rdc(EPC_CTRL_ADDR, 8'h02);
    cpu.bus_wr(EPC_CTRL_ADDR, 8'h00);
    rdc(16'h0901, EPC_ERASED_BYTE);
    rdc(16'h0902, 8'hC3);
    cpu.bus_wr(16'h0100, 8'h55);
    cpu.bus_wr(EPC_CTRL_ADDR, 8'h01);
    rdc(EPC_CTRL_ADDR, 8'h00);
    cpu.bus_wr(EPC_CTRL_ADDR, 8'hC0);
    rdc(EPC_CTRL_ADDR, 8'hC0);
    check({7'h00, off}, 8'h01);
    check({7'h00, bclk}, 8'h01);
    cpu.bus_wr(EPC_CTRL_ADDR, 8'h00);
    $display("test 2 done");
    cpu.op(EPC_BYTE_ERA, 16'h0902, 8'h00);
    rdc(16'h0902, EPC_ERASED_BYTE);
    cpu.op(EPC_BYTE_PGM, 16'h0900, 8'hAA);
    cpu.op(EPC_BLOCK_ERA, 16'h09C0, 8'h00);
    rdc(a, EPC_ERASED_BYTE);
    rdc(16'h0900, 8'hAA);
    cpu.op(EPC_BULK_ERA, 16'h0855, 8'h00);
    rdc(16'h0900, EPC_ERASED_BYTE);
    rdc(EPC_NVCFG_ADDR, EPC_NVCFG_INIT);
    $display("test 3 done");
    // Erase first, since protect bits must go from zero to one
    cpu.op(EPC_BYTE_ERA, EPC_NVCFG_ADDR, 8'h00);
    cpu.op(EPC_BYTE_PGM, EPC_NVCFG_ADDR, 8'h01);
    rdc(EPC_NVCFG_ADDR, 8'h01);
    rdc(EPC_SHADOW_ADDR, shd(8'h01));
    cpu.op(EPC_BYTE_PGM, 16'h0810, 8'h00);
    rdc(16'h0810, EPC_ERASED_BYTE);
    cpu.op(EPC_BYTE_PGM, 16'h0900, 8'hAA);
    cpu.op(EPC_BULK_ERA, 16'h0900, 8'h00);
    rdc(16'h0900, 8'hAA);
    cpu.op(EPC_BYTE_ERA, EPC_NVCFG_ADDR, 8'h00);
    cpu.op(EPC_BYTE_PGM, EPC_NVCFG_ADDR, 8'h80);
    rdc(EPC_SHADOW_ADDR, shd(8'h01));
    rdc(EPC_NVCFG_ADDR, 8'h80);
    rdc(EPC_SHADOW_ADDR, shd(8'h80));
    cpu.op(EPC_BYTE_PGM, 16'h0820, d);
    cpu.op(EPC_BYTE_PGM, 16'h0830, 8'h3C);
    cpu.op(EPC_BYTE_ERA, 16'h0830, 8'h00);
    cpu.op(EPC_BYTE_PGM, EPC_NVCFG_ADDR, 8'h00);
    rdc(EPC_NVCFG_ADDR, 8'h00);
    rdc(16'h0920, d);
    rdc(16'h0930, EPC_ERASED_BYTE);
    $display("test 4 done");
    summarize();
  end
endmodule
